//--- code_lock_pkg.sv
package code_lock_pkg;

    localparam int unsigned ADDR_W = 12;

    // status register index; its byte address is four times the index
    localparam logic [11:0] BOOT_STATUS_INDEX = 12'h0b2;
    localparam logic [11:0] BOOT_STATUS_ADDR = BOOT_STATUS_INDEX << 2;
    localparam logic [11:0] EMU_CTRL_ADDR = 12'h100;
    localparam logic [11:0] FLASH_STAT_ADDR = 12'h104;

    // boot_security_status fields
    localparam int unsigned EARLY_BOOT_BIT = 7;
    localparam int unsigned CODE_LOCK_BIT = 6;
    // emulator control field
    localparam int unsigned CLK_OFF_BIT = 0;
    // flash status fields
    localparam int unsigned ERASED_BIT = 0;
    localparam int unsigned REJECT_BIT = 1;

    // timing
    localparam int unsigned EARLY_BOOT_CYCLES = 32;
    localparam int unsigned RESET_TIMER_RTC_CYCLES = 4100;

    // flash geometry
    localparam int unsigned FLASH_ADDR_W = 16;
    localparam int unsigned PAGE_BYTES_LOG2 = 10;
    localparam logic [5:0] PAGE_ZERO = 6'h00;

    // debug port operations
    typedef enum logic [1:0] {
        DBG_GLOBAL_ERASE,
        DBG_PAGE_ERASE,
        DBG_WRITE,
        DBG_READ
    } dbg_op_e;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- flash_guard.sv
`timescale 1ns/1ns
`default_nettype none

module flash_guard (
    input wire logic [15:0] addr,
    input wire logic is_global,
    input wire logic lock,
    output logic allow
);

    function automatic logic [5:0] page_of(input logic [15:0] a);
        page_of = a[15:code_lock_pkg::PAGE_BYTES_LOG2];
    endfunction

    // page zero touched while locked is refused; global erase always passes
    always_comb begin
        allow = is_global || !(lock && page_of(addr) == code_lock_pkg::PAGE_ZERO);
    end

endmodule
`default_nettype wire

//--- code_lock.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - while locked, the debug port may only do a global flash erase.
// - first 32 cycles after reset form the early-boot window; lock set only there.
// - lock stays set until chip reset, with or without a global erase first.
// - global flash erase also clears the engine program RAM, locked or not.
// - debug port fully inhibited during the early-boot window.
// - bit 7 of status register reads high during the early-boot window.
// - after the window the debug port may take control, subject to the lock.
// - lock bit, bit 6 of status register, clears on every reset.
// - software can only set the lock bit; writing zero has no effect.
// - while locked no outside party can read program code.
// - page-zero page erase refused for software and debug port while locked.
// - writes to page zero from software or debug port blocked while locked.
// - writing one to emulator clock disable stops the emulator clock.
// - hold core in reset 4100 rtc cycles after external reset releases.

module code_lock #(
    parameter int unsigned RESET_RTC_CYCLES = code_lock_pkg::RESET_TIMER_RTC_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rtc_tick,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core flash requests
    input wire logic cpu_req,
    input wire logic cpu_erase,
    input wire logic [15:0] cpu_addr,
    output logic cpu_grant,
    output logic cpu_reject,
    // debug emulator port requests
    input wire logic dbg_req,
    input wire logic [1:0] dbg_op,
    input wire logic [15:0] dbg_addr,
    output logic dbg_grant,
    output logic dbg_reject,
    output logic dbg_control_en,
    output logic dbg_clk_en,
    // flash and engine ram controls, and core reset
    output logic flash_global_erase,
    output logic engine_ram_clear,
    output logic core_rst_n
);

    ////////////////////////////////////////////////////////////////////////////
    // reset synchroniser and core reset timer

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic rtc_meta_q;
    logic rtc_sync_q;
    logic rtc_prev_q;
    logic rtc_edge;
    logic [12:0] rst_cnt_q;
    logic core_run_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_meta_q <= 1'b0;
            rtc_sync_q <= 1'b0;
            rtc_prev_q <= 1'b0;
        end else begin
            rtc_meta_q <= rtc_tick;
            rtc_sync_q <= rtc_meta_q;
            rtc_prev_q <= rtc_sync_q;
        end
    end
    assign rtc_edge = rtc_sync_q && !rtc_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_q <= 13'h0;
            core_run_q <= 1'b0;
        end else if (!core_run_q && rtc_edge) begin
            if (rst_cnt_q == 13'(RESET_RTC_CYCLES - 1)) begin
                core_run_q <= 1'b1;
            end
            rst_cnt_q <= rst_cnt_q + 13'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_n <= 1'b0;
        end else begin
            core_rst_n <= core_run_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // early-boot window

    localparam logic [5:0] BOOT_LAST = 6'(code_lock_pkg::EARLY_BOOT_CYCLES - 1);
    logic [5:0] boot_cnt_q;
    logic early_boot_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_q <= 6'h0;
            early_boot_q <= 1'b0;
        end else if (core_run_q && !core_rst_n) begin
            early_boot_q <= 1'b1;
            boot_cnt_q <= 6'h0;
        end else if (early_boot_q) begin
            boot_cnt_q <= boot_cnt_q + 6'h1;
            if (boot_cnt_q == BOOT_LAST) begin
                early_boot_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic lock_q;
    logic emu_clk_off_q;
    logic erased_q;
    logic reject_seen_q;

    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= 12'h0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_hold_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_hold_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= code_lock_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == code_lock_pkg::BOOT_STATUS_ADDR
                || awaddr_q == code_lock_pkg::EMU_CTRL_ADDR
                || awaddr_q == code_lock_pkg::FLASH_STAT_ADDR)
                ? code_lock_pkg::RESP_OKAY : code_lock_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // lock bit: set only by ones during early boot, cleared only by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else if (wr_go && awaddr_q == code_lock_pkg::BOOT_STATUS_ADDR && wstrb_q[0]
            && wdata_q[code_lock_pkg::CODE_LOCK_BIT] && early_boot_q) begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            emu_clk_off_q <= 1'b0;
        end else if (wr_go && awaddr_q == code_lock_pkg::EMU_CTRL_ADDR && wstrb_q[0]) begin
            emu_clk_off_q <= wdata_q[code_lock_pkg::CLK_OFF_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= code_lock_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= code_lock_pkg::RESP_OKAY;
                s_axi_rdata <= 32'h0;
                unique case (s_axi_araddr)
                    code_lock_pkg::BOOT_STATUS_ADDR: begin
                        s_axi_rdata[code_lock_pkg::EARLY_BOOT_BIT] <= early_boot_q;
                        s_axi_rdata[code_lock_pkg::CODE_LOCK_BIT] <= lock_q;
                    end
                    code_lock_pkg::EMU_CTRL_ADDR: begin
                        s_axi_rdata[code_lock_pkg::CLK_OFF_BIT] <= emu_clk_off_q;
                    end
                    code_lock_pkg::FLASH_STAT_ADDR: begin
                        s_axi_rdata[code_lock_pkg::ERASED_BIT] <= erased_q;
                        s_axi_rdata[code_lock_pkg::REJECT_BIT] <= reject_seen_q;
                    end
                    default: begin
                        s_axi_rresp <= code_lock_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash request guards

    logic cpu_allow;
    logic dbg_allow_page;
    logic dbg_active;
    logic dbg_is_global;
    logic dbg_ok;

    flash_guard cpu_guard (
        .addr(cpu_addr),
        .is_global(1'b0),
        .lock(lock_q),
        .allow(cpu_allow)
    );

    flash_guard dbg_guard (
        .addr(dbg_addr),
        .is_global(dbg_is_global),
        .lock(lock_q),
        .allow(dbg_allow_page)
    );

    assign dbg_is_global = dbg_op == 2'(code_lock_pkg::DBG_GLOBAL_ERASE);
    // debug port lives only once the core runs, after early boot, with its clock on;
    // the timer flag leads core reset by a cycle and would open a gap before the window
    assign dbg_active = core_rst_n && !early_boot_q && !emu_clk_off_q;
    assign dbg_ok = dbg_active && (!lock_q || dbg_is_global) && dbg_allow_page;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_grant <= 1'b0;
            cpu_reject <= 1'b0;
        end else begin
            cpu_grant <= cpu_req && cpu_allow;
            cpu_reject <= cpu_req && !cpu_allow;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_grant <= 1'b0;
            dbg_reject <= 1'b0;
            dbg_control_en <= 1'b0;
            dbg_clk_en <= 1'b0;
        end else begin
            dbg_grant <= dbg_req && dbg_ok;
            dbg_reject <= dbg_req && !dbg_ok;
            dbg_control_en <= dbg_active && !lock_q;
            dbg_clk_en <= !emu_clk_off_q && !early_boot_q && core_rst_n;
        end
    end

    // global erase also wipes engine program ram, lock or no lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_global_erase <= 1'b0;
            engine_ram_clear <= 1'b0;
        end else begin
            flash_global_erase <= dbg_req && dbg_ok && dbg_is_global;
            engine_ram_clear <= dbg_req && dbg_ok && dbg_is_global;
        end
    end

    // erased flag survives until reset, which then leaves the lock clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erased_q <= 1'b0;
            reject_seen_q <= 1'b0;
        end else begin
            if (dbg_req && dbg_ok && dbg_is_global) begin
                erased_q <= 1'b1;
            end
            if ((cpu_req && !cpu_allow) || (dbg_req && !dbg_ok)) begin
                reject_seen_q <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- code_lock_properties.sv
`timescale 1ns/1ns
`default_nettype none
module code_lock_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dbg_req,
    input wire logic [1:0] dbg_op,
    input wire logic dbg_grant,
    input wire logic dbg_reject,
    input wire logic dbg_control_en,
    input wire logic dbg_clk_en,
    input wire logic cpu_req,
    input wire logic cpu_grant,
    input wire logic cpu_reject,
    input wire logic flash_global_erase,
    input wire logic engine_ram_clear,
    input wire logic core_rst_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // cycles since the core left reset, saturating
    logic [5:0] boot_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 6'h00;
        end else if (!core_rst_n) begin
            boot_q <= 6'h00;
        end else if (boot_q != 6'h3f) begin
            boot_q <= boot_q + 6'h01;
        end
    end
    sequence dbg_ask;
        dbg_req && core_rst_n && dbg_clk_en;
    endsequence
    sequence erase_ok;
        dbg_grant && $past(dbg_op) == code_lock_pkg::DBG_GLOBAL_ERASE;
    endsequence
    AST_DBG_ANSWER: assert property (dbg_ask |=> dbg_grant != dbg_reject)
        else $error("debug request unanswered");
    AST_DBG_QUIET: assert property (!dbg_req |=> !dbg_grant && !dbg_reject)
        else $error("debug answer without request");
    AST_BOOT_INHIBIT: assert property (boot_q < 6'h21 |-> !dbg_control_en && !dbg_grant)
        else $error("debug active in early boot");
    AST_LOCK_GLOBAL: assert property (dbg_grant && !dbg_control_en |-> erase_ok)
        else $error("locked debug did more than erase");
    AST_ERASE_RAM: assert property (erase_ok |-> flash_global_erase && engine_ram_clear)
        else $error("global erase without ram clear");
    AST_CORE_HELD: assert property (!core_rst_n |-> !dbg_grant && !dbg_control_en)
        else $error("debug active while core held");
    AST_CORE_STAYS: assert property (core_rst_n |=> core_rst_n)
        else $error("core reset returned");
    AST_CPU_ANSWER: assert property (cpu_req && core_rst_n |=> cpu_grant != cpu_reject)
        else $error("flash request unanswered");
    AST_CPU_QUIET: assert property (!cpu_req |=> !cpu_grant && !cpu_reject)
        else $error("flash answer without request");
    AST_CLK_OFF: assert property (!dbg_clk_en && !$past(dbg_clk_en) |-> !dbg_grant)
        else $error("grant with emulator clock stopped");
endmodule
bind code_lock code_lock_properties chk_i (.clk, .nrst, .dbg_req, .dbg_op, .dbg_grant,
    .dbg_reject, .dbg_control_en, .dbg_clk_en, .cpu_req, .cpu_grant, .cpu_reject,
    .flash_global_erase, .engine_ram_clear, .core_rst_n);
`default_nettype wire

//--- dbg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbg_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] op,
    input wire logic [15:0] addr,
    input wire logic dbg_grant,
    input wire logic dbg_reject,
    output logic dbg_req,
    output logic [1:0] dbg_op,
    output logic [15:0] dbg_addr,
    output logic seen_grant,
    output logic seen_reject
);
    initial begin
        dbg_req = 1'b0;
        dbg_op = 2'h3;
        dbg_addr = 16'h0000;
    end
    // one-cycle request; idle lines show the inverse of their last value
    always @(posedge clk) begin
        dbg_req <= go;
        dbg_op <= go ? op : ~dbg_op;
        dbg_addr <= go ? addr : ~dbg_addr;
        seen_grant <= dbg_grant;
        seen_reject <= dbg_reject;
    end
endmodule
`default_nettype wire

//--- code_lock_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module code_lock_tb_top;
    localparam logic [11:0] ST = code_lock_pkg::BOOT_STATUS_ADDR;
    logic clk = 1'b0, nrst = 1'b0, rtc_tick = 1'b0, go = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_req = 1'b0, cpu_erase = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [15:0] cpu_addr = 16'h0000, go_addr = 16'h0000, dbg_addr;
    logic [1:0] go_op = 2'h0, s_axi_bresp, s_axi_rresp, dbg_op, r;
    logic [2:0] rtc_div = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_grant;
    logic cpu_reject, dbg_req, dbg_grant, dbg_reject, dbg_control_en, dbg_clk_en, core_rst_n;
    logic flash_global_erase, engine_ram_clear, seen_grant, seen_reject;
    int bad_count = 0, comparisons = 0, seed = 2489, lock_m = 0, win_m = 1, ck_m = 1;
    int erase_n = 0, ram_n = 0, erase_exp = 0, p, op, k;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        rtc_div <= rtc_div + 3'h1;
        rtc_tick <= rtc_div[2];
        if (flash_global_erase === 1'b1) erase_n <= erase_n + 1;
        if (engine_ram_clear === 1'b1) ram_n <= ram_n + 1;
    end
    code_lock #(.RESET_RTC_CYCLES(4)) DUT (.clk, .nrst, .rtc_tick, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_erase, .cpu_addr, .cpu_grant,
        .cpu_reject, .dbg_req, .dbg_op, .dbg_addr, .dbg_grant, .dbg_reject, .dbg_control_en,
        .dbg_clk_en, .flash_global_erase, .engine_ram_clear, .core_rst_n);
    dbg_host_model host (.clk, .go, .op(go_op), .addr(go_addr), .dbg_grant, .dbg_reject,
        .dbg_req, .dbg_op, .dbg_addr, .seen_grant, .seen_reject);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic dbg_do(input int o, input logic [15:0] a);
        logic e;
        e = win_m == 0 && (lock_m == 0 || o == 0);
        @(posedge clk);
        go <= 1'b1;
        go_op <= o[1:0];
        go_addr <= a;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        chk(seen_grant, e && ck_m != 0);
        if (ck_m != 0) chk(seen_reject, !e);
        if (e && ck_m != 0 && o == 0) erase_exp++;
    endtask
    task automatic cpu_do(input logic er, input logic [15:0] a);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_erase <= er;
        cpu_addr <= a;
        @(posedge clk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        @(posedge clk);
        chk(cpu_grant, !(lock_m != 0 && a[15:10] == 6'h00));
        chk(cpu_reject, lock_m != 0 && a[15:10] == 6'h00);
    endtask
    // random address in page zero or in some other page
    function automatic logic [15:0] rnd(input int z);
        logic [15:0] v;
        v = 16'($random(seed));
        if (z == 0) v[15:10] = 6'h00;
        else if (v[15:10] == 6'h00) v[10] = 1'b1;
        return v;
    endfunction
    task automatic boot();
        nrst <= 1'b0;
        lock_m = 0;
        win_m = 1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(core_rst_n, 0);
        while (core_rst_n !== 1'b1) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (p = 0; p < 3; p++) begin
            boot();
            axr(ST);
            chk(d[7:6], 2'h2);
            if (p == 1) begin
                axw(ST, 32'h00000040);
                axw(ST, 32'h00000000);
                lock_m = 1;
            end
            dbg_do(0, 16'h0000);
            repeat (40) @(posedge clk);
            win_m = 0;
            axw(ST, 32'h000000c0);
            axr(ST);
            chk(d[7:6], lock_m);
            chk(dbg_control_en, !lock_m);
            for (op = 0; op < 4; op++) begin
                for (k = 0; k < 2; k++) begin
                    dbg_do(op, rnd(k));
                    cpu_do(op[0], rnd(k));
                end
            end
            chk(erase_n, erase_exp);
            chk(ram_n, erase_exp);
        end
        axw(code_lock_pkg::EMU_CTRL_ADDR, 32'h00000001);
        ck_m = 0;
        axr(code_lock_pkg::EMU_CTRL_ADDR);
        chk(d[0], 1);
        chk(dbg_clk_en, 0);
        dbg_do(3, 16'h0400);
        axr(12'h200);
        chk(r, code_lock_pkg::RESP_SLVERR);
        axw(12'h204, 32'h00000001);
        chk(r, code_lock_pkg::RESP_SLVERR);
        results();
    end
    initial begin
        #100000;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
